// ===== core/rss_pkg.sv
// constants, register map and carrier types for the receive signaling
// substitute-and-capture block; shared by the core and the bench.
// assumes a 32-bit apb with word-aligned registers, index = byte address / 4.
package rss_pkg;
    // apb address width and register word indices (byte address = index * 4)
    localparam int APB_AW = 16;
    localparam logic [13:0] IDX_SUB_BASE = 14'h03C0;
    localparam logic [13:0] IDX_CAP_BASE = 14'h0500;
    localparam logic [13:0] IDX_CTL_BASE = 14'h0340;
    localparam logic [13:0] IDX_CFG = 14'h0107;
    localparam int NUM_TS_DOC = 24;

    // global config register fields
    localparam int CFG_SF_UPDATE_BIT = 7;
    localparam int CFG_DEBOUNCE_BIT = 6;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_WMASK = 8'hC0;

    // per-timeslot control: substitution select [3:2], extraction select [1:0]
    localparam int CTL_SUB_LSB = 2;
    localparam int CTL_EXT_LSB = 0;
    localparam logic [3:0] CTL_RESET = 4'h0;
    localparam logic [3:0] SUB_RESET = 4'h0;
    localparam logic [3:0] CAP_RESET = 4'h0;

    // signaling bit positions inside an abcd nibble
    localparam int BIT_A = 3;
    localparam int BIT_B = 2;
    localparam int BIT_C = 1;
    localparam int BIT_D = 0;
    localparam logic [3:0] ABCD_ONES = 4'hF;

    // substitution select codes
    localparam logic [1:0] SUB_ALL_ONES = 2'h0;
    localparam logic [1:0] SUB_16CODE = 2'h1;
    localparam logic [1:0] SUB_4CODE = 2'h2;
    localparam logic [1:0] SUB_2CODE = 2'h3;

    // extraction select codes
    localparam logic [1:0] EXT_NONE = 2'h0;
    localparam logic [1:0] EXT_ABCD = 2'h1;
    localparam logic [1:0] EXT_AB = 2'h2;
    localparam logic [1:0] EXT_A = 2'h3;

    // one signaling sample of one timeslot, in or out
    typedef struct packed {
        logic valid;
        logic [4:0] ts;
        logic [3:0] abcd;
    } rss_sig_s;
endpackage : rss_pkg

// ===== core/rss_core.sv
// receive signaling substitution and per-timeslot signaling capture,
// with an apb slave for the substitute values, capture records and controls.
// assumes the framer gives one valid sample per timeslot per superframe,
// a one-cycle superframe boundary pulse, and everything on one clock.
`timescale 1ns/1ps
`default_nettype none
module rss_core
    import rss_pkg::*;
#(
    parameter int NUM_TS = NUM_TS_DOC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rss_sig_s rx_in,
    input wire logic sf_boundary,
    output rss_sig_s rx_out
);
    localparam logic [13:0] TS_SPAN = 14'(NUM_TS);
    localparam logic [4:0] TS_LIMIT = 5'(NUM_TS);

    // register storage, packed so whole arrays can be compared
    logic [NUM_TS-1:0][3:0] sub_reg;
    logic [NUM_TS-1:0][3:0] ctl_reg;
    logic [NUM_TS-1:0][3:0] cap_reg;
    logic [NUM_TS-1:0][3:0] last_reg;
    logic [NUM_TS-1:0][3:0] stage_reg;
    logic [NUM_TS-1:0] stage_vld_reg;
    logic [7:0] cfg_reg;
    logic [31:0] prdata_reg;
    logic err_reg;
    rss_sig_s out_reg;

    // apb address decode
    wire logic [13:0] word_idx = paddr[15:2];
    wire logic [13:0] sub_off = word_idx - IDX_SUB_BASE;
    wire logic [13:0] cap_off = word_idx - IDX_CAP_BASE;
    wire logic [13:0] ctl_off = word_idx - IDX_CTL_BASE;
    wire logic sub_hit = (word_idx >= IDX_SUB_BASE) && (sub_off < TS_SPAN);
    wire logic cap_hit = (word_idx >= IDX_CAP_BASE) && (cap_off < TS_SPAN);
    wire logic ctl_hit = (word_idx >= IDX_CTL_BASE) && (ctl_off < TS_SPAN);
    wire logic cfg_hit = (word_idx == IDX_CFG);
    wire logic any_hit = sub_hit | cap_hit | ctl_hit | cfg_hit;
    wire logic [4:0] sub_ts = sub_off[4:0];
    wire logic [4:0] cap_ts = cap_off[4:0];
    wire logic [4:0] ctl_ts = ctl_off[4:0];
    wire logic setup_ph = psel & ~penable;
    wire logic wr_acc = psel & penable & pwrite & pstrb[0];

    // read mux; upper bits are always zero
    wire logic [3:0] rd_nib = sub_hit ? sub_reg[sub_ts] :
                              cap_hit ? cap_reg[cap_ts] :
                              ctl_hit ? ctl_reg[ctl_ts] : 4'h0;
    wire logic [7:0] rd_byte = cfg_hit ? cfg_reg : {4'h0, rd_nib};
    wire logic [31:0] rd_data = {24'h000000, rd_byte};

    // zero wait states: data and error are caught in setup, shown in access
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = err_reg & psel & penable;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_reg <= 32'h00000000;
            err_reg <= 1'b0;
        end else if (setup_ph) begin
            prdata_reg <= pwrite ? 32'h00000000 : rd_data;
            err_reg <= ~any_hit;
        end
    end

    // software writes; capture records take no write at all
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sub_reg <= {NUM_TS{SUB_RESET}};
            ctl_reg <= {NUM_TS{CTL_RESET}};
            cfg_reg <= CFG_RESET;
        end else if (wr_acc) begin
            if (sub_hit) begin
                sub_reg[sub_ts] <= pwdata[3:0];
            end
            if (ctl_hit) begin
                ctl_reg[ctl_ts] <= pwdata[3:0];
            end
            if (cfg_hit) begin
                cfg_reg <= pwdata[7:0] & CFG_WMASK;
            end
        end
    end

    // receive-side selection for the incoming timeslot
    wire logic in_ok = rx_in.valid && (rx_in.ts < TS_LIMIT);
    wire logic [4:0] ts_safe = in_ok ? rx_in.ts : 5'h00;
    wire logic [3:0] cur_ctl = ctl_reg[ts_safe];
    wire logic [3:0] sub_now = sub_reg[ts_safe];
    wire logic [1:0] sub_sel = cur_ctl[CTL_SUB_LSB +: 2];
    wire logic [1:0] ext_sel = cur_ctl[CTL_EXT_LSB +: 2];
    wire logic deb_en = cfg_reg[CFG_DEBOUNCE_BIT];
    wire logic sf_mode = deb_en & cfg_reg[CFG_SF_UPDATE_BIT];

    // substitution of the robbed-bit signaling
    wire logic rep_a = (sub_sel != SUB_ALL_ONES);
    wire logic rep_b = (sub_sel == SUB_16CODE) || (sub_sel == SUB_4CODE);
    wire logic rep_cd = (sub_sel == SUB_16CODE);
    wire logic [3:0] sub_abcd = (sub_sel == SUB_ALL_ONES) ? ABCD_ONES : {
        rep_a ? sub_now[BIT_A] : rx_in.abcd[BIT_A],
        rep_b ? sub_now[BIT_B] : rx_in.abcd[BIT_B],
        rep_cd ? sub_now[BIT_C] : rx_in.abcd[BIT_C],
        rep_cd ? sub_now[BIT_D] : rx_in.abcd[BIT_D]
    };

    // extraction masks the record; unextracted bits read as zero
    wire logic [3:0] cand = (ext_sel == EXT_ABCD) ? rx_in.abcd :
                            (ext_sel == EXT_AB) ? {rx_in.abcd[3:2], 2'b00} :
                            {rx_in.abcd[3], 3'b000};
    wire logic ext_on = (ext_sel != EXT_NONE);
    wire logic same = (rx_in.abcd == last_reg[ts_safe]);
    wire logic upd_now = in_ok && ext_on && !sf_mode && (!deb_en || same);
    wire logic stage_set = in_ok && ext_on && sf_mode && same;

    // substituted sample out, one cycle behind the input
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            out_reg <= '0;
        end else begin
            out_reg.valid <= in_ok;
            out_reg.ts <= ts_safe;
            out_reg.abcd <= sub_abcd;
        end
    end
    assign rx_out = out_reg;

    // previous-superframe raw value per timeslot for the debounce compare
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            last_reg <= {NUM_TS{CAP_RESET}};
        end else if (in_ok) begin
            last_reg[ts_safe] <= rx_in.abcd;
        end
    end

    // capture records; a sample that lands on the boundary cycle stays staged
    // for the next boundary, so the set wins over the clear
    // leaving boundary mode drops any parked value, else it would land late
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cap_reg <= {NUM_TS{CAP_RESET}};
            stage_reg <= {NUM_TS{CAP_RESET}};
            stage_vld_reg <= '0;
        end else begin
            for (int i = 0; i < NUM_TS; i++) begin
                if (!sf_mode) begin
                    stage_vld_reg[i] <= 1'b0;
                end else if (sf_boundary && stage_vld_reg[i]) begin
                    cap_reg[i] <= stage_reg[i];
                    stage_vld_reg[i] <= 1'b0;
                end
            end
            if (upd_now) begin
                cap_reg[ts_safe] <= cand;
            end
            if (stage_set) begin
                stage_reg[ts_safe] <= cand;
                stage_vld_reg[ts_safe] <= 1'b1;
            end
        end
    end

    // checks on substitution
    a_sub_all_ones: assert property (@(posedge clock) disable iff (sys_rst)
        in_ok && sub_sel == SUB_ALL_ONES |=> rx_out.valid && rx_out.abcd == ABCD_ONES)
        else $error("all-ones substitution missing");
    a_sub_16code: assert property (@(posedge clock) disable iff (sys_rst)
        in_ok && sub_sel == SUB_16CODE |=> rx_out.abcd == $past(sub_now))
        else $error("16-code substitution wrong");
    a_sub_4code: assert property (@(posedge clock) disable iff (sys_rst)
        in_ok && sub_sel == SUB_4CODE
        |=> rx_out.abcd == {$past(sub_now[3:2]), $past(rx_in.abcd[1:0])})
        else $error("4-code substitution wrong");
    a_sub_2code: assert property (@(posedge clock) disable iff (sys_rst)
        in_ok && sub_sel == SUB_2CODE
        |=> rx_out.abcd == {$past(sub_now[3]), $past(rx_in.abcd[2:0])})
        else $error("2-code substitution wrong");

    // checks on capture
    a_cap_quiet: assert property (@(posedge clock) disable iff (sys_rst)
        !in_ok && !sf_boundary |=> $stable(cap_reg))
        else $error("capture record changed without a sample");
    a_debounce_hold: assert property (@(posedge clock) disable iff (sys_rst)
        in_ok && deb_en && !same && !sf_boundary |=> $stable(cap_reg))
        else $error("debounce let a changed state through");
    a_debounce_take: assert property (@(posedge clock) disable iff (sys_rst)
        in_ok && deb_en && !sf_mode && same && ext_sel == EXT_ABCD
        |=> cap_reg[$past(ts_safe)] == $past(rx_in.abcd))
        else $error("debounced state not captured");
    a_cap_immediate: assert property (@(posedge clock) disable iff (sys_rst)
        in_ok && !deb_en && ext_sel == EXT_ABCD
        |=> cap_reg[$past(ts_safe)] == $past(rx_in.abcd))
        else $error("record not refreshed at once");
    a_sf_only: assert property (@(posedge clock) disable iff (sys_rst)
        sf_mode && !sf_boundary && !$past(wr_acc) |=> $stable(cap_reg))
        else $error("record refreshed off the boundary");
    a_extract_ab: assert property (@(posedge clock) disable iff (sys_rst)
        in_ok && !deb_en && ext_sel == EXT_AB
        |=> cap_reg[$past(ts_safe)] == {$past(rx_in.abcd[3:2]), 2'b00})
        else $error("a-b extraction wrong");
    a_reserved_zero: assert property (@(posedge clock) disable iff (sys_rst)
        setup_ph && !pwrite && (sub_hit || cap_hit) |=> prdata[31:4] == 28'h0000000)
        else $error("reserved bits read nonzero");

    // checks on the receive path
    // every accepted sample leaves one cycle later
    a_out_valid: assert property (@(posedge clock) disable iff (sys_rst)
        in_ok |=> rx_out.valid)
        else $error("accepted sample not passed on");
    // nothing leaves without an accepted sample
    a_out_idle: assert property (@(posedge clock) disable iff (sys_rst)
        !in_ok |=> !rx_out.valid)
        else $error("output valid without a sample");
    // the timeslot number rides along unchanged
    a_out_slot: assert property (@(posedge clock) disable iff (sys_rst)
        in_ok |=> rx_out.ts == $past(rx_in.ts))
        else $error("output timeslot wrong");
    // timeslots past the last one are dropped
    a_slot_refused: assert property (@(posedge clock) disable iff (sys_rst)
        rx_in.valid && rx_in.ts >= TS_LIMIT |=> !rx_out.valid)
        else $error("out-of-range timeslot passed on");

    // checks on extraction and the capture records
    // extraction off never touches a record
    a_ext_none: assert property (@(posedge clock) disable iff (sys_rst)
        in_ok && ext_sel == EXT_NONE && !sf_boundary |=> $stable(cap_reg))
        else $error("record changed with extraction off");
    // a-only extraction clears b, c and d
    a_extract_a: assert property (@(posedge clock) disable iff (sys_rst)
        in_ok && !deb_en && ext_sel == EXT_A
        |=> cap_reg[$past(ts_safe)] == {$past(rx_in.abcd[3]), 3'b000})
        else $error("a-only extraction wrong");
    // debounced a-b capture keeps the mask
    a_debounce_ab: assert property (@(posedge clock) disable iff (sys_rst)
        in_ok && deb_en && !sf_mode && same && ext_sel == EXT_AB
        |=> cap_reg[$past(ts_safe)] == {$past(rx_in.abcd[3:2]), 2'b00})
        else $error("debounced a-b state not captured");
    // previous raw value kept for the next compare
    a_last_track: assert property (@(posedge clock) disable iff (sys_rst)
        in_ok |=> last_reg[$past(ts_safe)] == $past(rx_in.abcd))
        else $error("debounce history not kept");
    // software writes never reach a record
    a_cap_nowrite: assert property (@(posedge clock) disable iff (sys_rst)
        wr_acc && cap_hit && !in_ok && !sf_boundary |=> $stable(cap_reg))
        else $error("software write reached a record");
    // record read returns the stored nibble
    a_cap_read: assert property (@(posedge clock) disable iff (sys_rst)
        setup_ph && !pwrite && cap_hit
        |=> prdata == {28'h0000000, $past(cap_reg[cap_ts])})
        else $error("record read wrong");

    // checks on boundary-mode staging
    // an equal sample is parked until the boundary
    a_stage_load: assert property (@(posedge clock) disable iff (sys_rst)
        stage_set
        |=> stage_vld_reg[$past(ts_safe)] && stage_reg[$past(ts_safe)] == $past(cand))
        else $error("debounced sample not staged");
    // a changed sample stages nothing
    a_stage_hold: assert property (@(posedge clock) disable iff (sys_rst)
        in_ok && sf_mode && !same |=> $stable(stage_reg))
        else $error("changed sample was staged");
    // the boundary moves a parked value into its record
    a_stage_move: assert property (@(posedge clock) disable iff (sys_rst)
        sf_mode && sf_boundary && stage_vld_reg[ts_safe]
        |=> cap_reg[$past(ts_safe)] == $past(stage_reg[ts_safe]))
        else $error("staged value not moved on the boundary");
    // leaving boundary mode drops whatever was parked
    a_stage_flush: assert property (@(posedge clock) disable iff (sys_rst)
        !sf_mode |=> stage_vld_reg == '0)
        else $error("stale stage kept outside boundary mode");
    // immediate mode moves nothing without a sample
    a_imm_quiet: assert property (@(posedge clock) disable iff (sys_rst)
        !sf_mode && !in_ok |=> $stable(cap_reg))
        else $error("record changed with no sample");

    // checks on the register file
    // substitute values store the low nibble
    a_sub_store: assert property (@(posedge clock) disable iff (sys_rst)
        wr_acc && sub_hit |=> sub_reg[$past(sub_ts)] == $past(pwdata[3:0]))
        else $error("substitute value not stored");
    // controls store both select fields
    a_ctl_store: assert property (@(posedge clock) disable iff (sys_rst)
        wr_acc && ctl_hit |=> ctl_reg[$past(ctl_ts)] == $past(pwdata[3:0]))
        else $error("control not stored");
    // only the two mode bits of the config stick
    a_cfg_store: assert property (@(posedge clock) disable iff (sys_rst)
        wr_acc && cfg_hit |=> cfg_reg == ($past(pwdata[7:0]) & CFG_WMASK))
        else $error("config bits stored wrong");
    // substitute read returns the stored nibble
    a_sub_read: assert property (@(posedge clock) disable iff (sys_rst)
        setup_ph && !pwrite && sub_hit
        |=> prdata == {28'h0000000, $past(sub_reg[sub_ts])})
        else $error("substitute read wrong");
    // control read returns both select fields
    a_ctl_read: assert property (@(posedge clock) disable iff (sys_rst)
        setup_ph && !pwrite && ctl_hit
        |=> prdata == {28'h0000000, $past(ctl_reg[ctl_ts])})
        else $error("control read wrong");
    // config read shows only the two mode bits
    a_cfg_read: assert property (@(posedge clock) disable iff (sys_rst)
        setup_ph && !pwrite && cfg_hit
        |=> prdata == {24'h000000, $past(cfg_reg)})
        else $error("config read wrong");
    // an unmapped read returns zero
    a_read_unmapped: assert property (@(posedge clock) disable iff (sys_rst)
        setup_ph && !pwrite && !any_hit
        |=> prdata == 32'h00000000)
        else $error("unmapped read not zero");
    // a write cycle shows no stale read data
    a_write_quiet: assert property (@(posedge clock) disable iff (sys_rst)
        setup_ph && pwrite
        |=> prdata == 32'h00000000)
        else $error("read data shown during a write");
    // a cleared strobe leaves every writable register alone
    a_strobe_off: assert property (@(posedge clock) disable iff (sys_rst)
        psel && penable && pwrite && !pstrb[0]
        |=> $stable(sub_reg) && $stable(ctl_reg) && $stable(cfg_reg))
        else $error("write with strobe off took effect");
endmodule : rss_core
`default_nettype wire

// ===== tb/rss_framer_model.sv
// framer stand-in: sends one signaling sample or one boundary pulse per call
// assumes one bench process calls its tasks, always on the rising edge
`timescale 1ns/1ps
`default_nettype none
module rss_framer_model
    import rss_pkg::*;
(
    input wire logic clock,
    output rss_sig_s rx_in,
    output logic sf_boundary
);
    // idle lines start low, no sample pending
    initial begin
        rx_in = '0;
        sf_boundary = 1'b0;
    end
    // one-cycle valid; released lines invert so stale data never looks good
    task automatic send(input logic [4:0] ts, input logic [3:0] abcd);
        begin
            @(posedge clock);
            rx_in <= {1'b1, ts, abcd};
            @(posedge clock);
            rx_in <= {1'b0, ~ts, ~abcd};
        end
    endtask : send
    // superframe marker, one cycle wide
    task automatic boundary();
        begin
            @(posedge clock);
            sf_boundary <= 1'b1;
            @(posedge clock);
            sf_boundary <= 1'b0;
        end
    endtask : boundary
endmodule : rss_framer_model
`default_nettype wire

// ===== tb/rss_core_tb_top.sv
// self-checking bench for the signaling substitute-and-capture core
// assumes zero-wait apb slave and the framer model driving the receive side
`timescale 1ns/1ps
`default_nettype none
module rss_core_tb_top
    import rss_pkg::*;
;
    logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, sf_boundary, er;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    rss_sig_s rx_in, rx_out;
    int err_total = 0;
    int checked = 0;
    rss_core i_rss_core (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_in(rx_in), .sf_boundary(sf_boundary),
        .rx_out(rx_out));
    rss_framer_model i_rss_framer_model (.clock(clock), .rx_in(rx_in),
        .sf_boundary(sf_boundary));
    // 50 MHz
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one apb transfer; waits on pready, data taken at that edge
    task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input string what, input logic [13:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(what, rd, exp);
    endtask : rdc
    // sample lands in rx_out at the edge send returns on
    task automatic smp(input logic [4:0] ts, input logic [3:0] abcd);
        i_rss_framer_model.send(ts, abcd);
        #1;
    endtask : smp
    task automatic t_regs();
        rdc("sub reset", IDX_SUB_BASE, 32'h0);
        rdc("cap reset", IDX_CAP_BASE, 32'h0);
        apb(1'b1, IDX_SUB_BASE + 14'h2, 32'hFFFFFFFF);
        rdc("sub upper", IDX_SUB_BASE + 14'h2, 32'h0000000F);
        apb(1'b1, IDX_CAP_BASE + 14'h3, 32'h0000000F);
        chk("cap write err", {31'h0, er}, 32'h0);
        rdc("cap write", IDX_CAP_BASE + 14'h3, 32'h0);
        pstrb <= 4'hE;
        apb(1'b1, IDX_SUB_BASE + 14'h2, 32'h00000000);
        pstrb <= 4'hF;
        rdc("sub strobe", IDX_SUB_BASE + 14'h2, 32'h0000000F);
    endtask : t_regs
    // every select code against programmed 1010 and received 0101
    task automatic t_subst();
        logic [3:0] exp [4] = '{4'hF, 4'hA, 4'h9, 4'hD};
        apb(1'b1, IDX_SUB_BASE + 14'h5, 32'h0000000A);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, IDX_CTL_BASE + 14'h5, {28'h0, s[1:0], EXT_ABCD});
            smp(5'h05, 4'h5);
            chk("out valid", {31'h0, rx_out.valid}, 32'h1);
            chk("out ts", {27'h0, rx_out.ts}, 32'h00000005);
            chk("out abcd", {28'h0, rx_out.abcd}, {28'h0, exp[s]});
            rdc("cap raw", IDX_CAP_BASE + 14'h5, 32'h00000005);
        end
    endtask : t_subst
    // none first, so the record still holds its reset value
    task automatic t_extract();
        logic [3:0] exp [4] = '{4'h0, 4'hF, 4'hC, 4'h8};
        for (int e = 0; e < 4; e++) begin
            apb(1'b1, IDX_CTL_BASE + 14'h6, {28'h0, SUB_16CODE, e[1:0]});
            smp(5'h06, 4'hF);
            rdc("cap extract", IDX_CAP_BASE + 14'h6, {28'h0, exp[e]});
        end
    endtask : t_extract
    task automatic t_debounce();
        apb(1'b1, IDX_CFG, 32'h00000040);
        apb(1'b1, IDX_CTL_BASE + 14'h7, 32'h00000005);
        smp(5'h07, 4'h3);
        rdc("db first", IDX_CAP_BASE + 14'h7, 32'h0);
        smp(5'h07, 4'h3);
        rdc("db equal", IDX_CAP_BASE + 14'h7, 32'h00000003);
        smp(5'h07, 4'h6);
        rdc("db change", IDX_CAP_BASE + 14'h7, 32'h00000003);
    endtask : t_debounce
    task automatic t_boundary();
        apb(1'b1, IDX_CFG, 32'h000000FF);
        rdc("cfg mask", IDX_CFG, 32'h000000C0);
        apb(1'b1, IDX_CTL_BASE + 14'h8, 32'h00000001);
        smp(5'h08, 4'h9);
        smp(5'h08, 4'h9);
        rdc("sf wait", IDX_CAP_BASE + 14'h8, 32'h0);
        i_rss_framer_model.boundary();
        rdc("sf update", IDX_CAP_BASE + 14'h8, 32'h00000009);
    endtask : t_boundary
    // unmapped word and an out-of-range timeslot are both refused
    task automatic t_refused();
        apb(1'b0, 14'h0200, 32'h0);
        chk("unmapped err", {31'h0, er}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        chk("ready", {31'h0, pready}, 32'h1);
        smp(5'd24, 4'h7);
        chk("ts24 valid", {31'h0, rx_out.valid}, 32'h0);
    endtask : t_refused
    // mid-run reset brings every register and record back to zero
    task automatic t_reset();
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rdc("rst sub", IDX_SUB_BASE + 14'h5, 32'h0);
        rdc("rst cap", IDX_CAP_BASE + 14'h8, 32'h0);
        rdc("rst cfg", IDX_CFG, 32'h0);
    endtask : t_reset
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    // reset for six cycles, then the scenarios in turn
    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite} = 3'b000;
        paddr = 16'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        t_regs();
        t_subst();
        t_extract();
        t_debounce();
        t_boundary();
        t_refused();
        t_reset();
        give_verdict();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        #400000;
        err_total++;
        give_verdict();
    end
endmodule : rss_core_tb_top
`default_nettype wire
